// ==== hdl/job_module.sv ====
`timescale 1ns/1ps
`default_nettype none
// module end: runs jobs, keeps images, front panel
module job_module
	import job_status_pkg::*;
#(
	parameter int IMG_W = 16,
	parameter int SLAVES = 31,
	parameter int POLL_CLKS = POLL_CYCLE_CLKS
) (
	input wire logic pclk,
	input wire logic presetn,
	job_link_if.dev link,
	input wire logic [IMG_W-1:0] slave_in_image,
	input wire logic [SLAVES-1:0] slave_present,
	input wire logic bus_power_ok,
	input wire logic sw_store_cfg,
	input wire logic sw_mode,
	output logic [IMG_W-1:0] slave_out_image,
	output logic led_cfg_ok,
	output logic led_power_fail,
	output logic auto_addr_en
);
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_XFER = 2'b01,
		S_DONE = 2'b10
	} job_state_t;

	job_state_t state_q;
	logic [7:0] num_q;
	logic rx_q;
	logic [3:0] err_q;
	logic [7:0] left_q;
	logic [7:0] moved_q;
	logic [SLAVES-1:0] expected_q;
	logic sw_store_q;
	logic poll_tick;
	logic store_req;

	// assemble a status word; reserved and transfer-active stay zero
	function automatic logic [15:0] status_word(input logic active, input logic rx,
			input logic [3:0] err, input logic fin);
		logic [15:0] w;
		w = 16'h0000; // RULE_08 RULE_19
		w[ST_ACTIVE] = active; // RULE_04 RULE_17
		if (fin && err == ERR_NONE) begin
			w[ST_OK] = 1'b1; // RULE_17
			w[ST_RX_AVAIL] = rx; // RULE_17
			w[DM_ACCEPT_OK] = rx; // RULE_05
			w[DM_SEND_OK] = !rx; // RULE_05
		end
		if (fin && err != ERR_NONE) begin
			w[ST_ERR] = 1'b1; // RULE_17
			w[ERR_LSB +: 4] = err; // RULE_07
		end
		w[DM_XFER_ACT] = 1'b0; // RULE_05 RULE_19
		w[DM_GATE] = 1'b0; // RULE_06
		return w;
	endfunction

	// decide the device-side error code for a new job
	function automatic logic [3:0] job_check(input logic [7:0] num, input logic [7:0] len,
			input logic gate, input logic mode);
		logic [3:0] e;
		e = ERR_NONE;
		if (gate) begin
			e = ERR_PARAM_UNSUP; // RULE_06 RULE_18
		end else if (num == JOB_SEND_IMG && len != SEND_IMG_WORDS) begin
			e = ERR_PARAM_UNSUP; // RULE_18
		end else if (num == JOB_CFG && mode == MODE_PROTECTED) begin
			e = ERR_NOT_PERMITTED; // RULE_04 RULE_18
		end
		return e;
	endfunction

	// polling cycle enable; whole cycle fixed regardless of slave count
	tick_divider #(.DIV(POLL_CLKS)) u_poll (
		.pclk(pclk),
		.presetn(presetn),
		.tick(poll_tick)
	); // RULE_11

	// job sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= S_IDLE;
			num_q <= 8'h00;
			rx_q <= 1'b0;
			err_q <= ERR_NONE;
			left_q <= 8'h00;
			moved_q <= 8'h00;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					if (link.start && job_valid(link.job_num)) begin // RULE_01
						num_q <= link.job_num;
						rx_q <= link.job_rx;
						err_q <= job_check(link.job_num, link.len_words, link.gate, sw_mode);
						left_q <= link.len_words;
						moved_q <= 8'h00;
						if (job_check(link.job_num, link.len_words, link.gate, sw_mode) != ERR_NONE
								|| link.len_words == 8'h00) begin
							state_q <= S_DONE;
						end else begin
							state_q <= S_XFER;
						end
					end
				end
				S_XFER: begin
					// one data word per clock
					left_q <= left_q - 8'h01;
					moved_q <= moved_q + 8'h01; // RULE_03
					if (left_q == 8'h01) begin
						state_q <= S_DONE;
					end
				end
				S_DONE: begin
					state_q <= S_IDLE;
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// record towards the controller: status word then length word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link.busy <= 1'b0;
			link.done <= 1'b0;
			link.done_num <= 8'h00;
			link.stat_word <= 16'h0000;
			link.len_word <= 16'h0000;
		end else begin
			link.done <= 1'b0;
			if (state_q == S_IDLE && link.start && job_valid(link.job_num)) begin
				link.busy <= 1'b1;
				link.done_num <= link.job_num;
				link.stat_word <= status_word(1'b1, 1'b0, ERR_NONE, 1'b0); // RULE_04
				link.len_word <= 16'h0000;
			end else if (state_q == S_DONE) begin
				link.busy <= 1'b0;
				link.done <= 1'b1;
				link.stat_word <= status_word(1'b0, rx_q, err_q, 1'b1); // RULE_02
				link.len_word <= {8'h00, moved_q}; // RULE_02 RULE_03
			end
		end
	end

	// parameter error byte, separate from the status word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link.perr <= 1'b0;
			link.perr_byte <= PERR_NONE;
		end else begin
			link.perr <= 1'b0;
			if (link.start && state_q == S_IDLE) begin
				if (!job_valid(link.job_num)) begin // RULE_01
					link.perr <= 1'b1; // RULE_10
					link.perr_byte <= PERR_BAD_JOB; // RULE_10
				end else begin
					link.perr_byte <= PERR_NONE;
				end
			end
		end
	end

	// images swapped once per polling cycle, host sees them directly
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link.in_image <= '0;
			slave_out_image <= '0;
		end else if (poll_tick) begin
			link.in_image <= slave_in_image; // RULE_12
			slave_out_image <= link.out_image; // RULE_12
		end
	end

	// switch edge; only honoured in configuration mode
	assign store_req = (sw_store_cfg && !sw_store_q && sw_mode == MODE_CONFIG)
		|| (state_q == S_DONE && num_q == JOB_CFG && err_q == ERR_NONE);

	// expected configuration store
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_store_q <= 1'b0;
			expected_q <= '0;
		end else begin
			sw_store_q <= sw_store_cfg;
			if (store_req) begin
				expected_q <= slave_present; // RULE_13 RULE_14
			end
		end
	end

	// config-ok and power-fail to error bits and LEDs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link.cfg_ok <= 1'b0;
			link.bus_power_fail_flag <= 1'b0;
			led_cfg_ok <= 1'b0;
			led_power_fail <= 1'b0;
		end else begin
			link.cfg_ok <= (slave_present == expected_q); // RULE_15
			led_cfg_ok <= (slave_present == expected_q); // RULE_15
			link.bus_power_fail_flag <= !bus_power_ok; // RULE_15
			led_power_fail <= !bus_power_ok; // RULE_15
		end
	end

	// auto address enable is the only settable function here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auto_addr_en <= 1'b0;
			link.auto_en_rb <= 1'b0;
		end else begin
			auto_addr_en <= link.auto_en; // RULE_16
			link.auto_en_rb <= auto_addr_en; // RULE_16
		end
	end
endmodule
`default_nettype wire

// ==== hdl/job_status_pkg.sv ====
// Overview of operation
// RULE_01 - only jobs 200-202; distinct number per job
// RULE_02 - record is status word then length word
// RULE_03 - length word gets words moved at completion
// RULE_04 - bits 0-3 report job status
// RULE_05 - bits 4-7 report data management
// RULE_06 - gate bit 1 blocks, kept at 0
// RULE_07 - error nibble 8-11, valid only with error bit
// RULE_08 - bits 12-15 reserved, no function
// RULE_09 - host reads status right after each job
// RULE_10 - bad job parameters reported in error byte
// RULE_11 - polling cycle no longer than 5 ms
// RULE_12 - images exchanged through direct I/O access
// RULE_13 - front switch stores present configuration
// RULE_14 - front switch selects operating mode
// RULE_15 - config-ok and power-fail: error bit plus LED
// RULE_16 - auto address enable only; nothing else
// RULE_17 - nibble: rx avail, active, ok, error
// RULE_18 - codes 0-5 from host, 6-F from device
// RULE_19 - reserved and transfer-active bits driven zero
package job_status_pkg;
	localparam logic [7:0] JOB_FIRST = 8'hC8;
	localparam logic [7:0] JOB_LAST = 8'hCA;
	localparam logic [7:0] JOB_SEND_IMG = 8'hC8;
	localparam logic [7:0] JOB_CFG = 8'hCA;
	localparam logic [7:0] SEND_IMG_WORDS = 8'h08;
	// status word bit positions
	localparam int ST_RX_AVAIL = 0;
	localparam int ST_ACTIVE = 1;
	localparam int ST_OK = 2;
	localparam int ST_ERR = 3;
	localparam int DM_XFER_ACT = 4;
	localparam int DM_SEND_OK = 5;
	localparam int DM_ACCEPT_OK = 6;
	localparam int DM_GATE = 7;
	localparam int ERR_LSB = 8;
	// error nibble codes
	localparam logic [3:0] ERR_NONE = 4'h0;
	localparam logic [3:0] ERR_GATED = 4'h1;
	localparam logic [3:0] ERR_PARAM_UNSUP = 4'h6;
	localparam logic [3:0] ERR_NOT_PERMITTED = 4'h8;
	localparam logic [7:0] PERR_NONE = 8'h00;
	localparam logic [7:0] PERR_BAD_JOB = 8'h01;
	localparam logic MODE_CONFIG = 1'b0;
	localparam logic MODE_PROTECTED = 1'b1;
	// polling cycle bound
	localparam int POLL_CYCLE_US = 5000;
	localparam int CLK_FREQ_MHZ = 200;
	localparam int POLL_CYCLE_CLKS = POLL_CYCLE_US * CLK_FREQ_MHZ;
	// controller register map
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_OUT_IMG = 8'h08;
	localparam logic [7:0] REG_IN_IMG = 8'h0C;
	localparam logic [7:0] REG_JOB_REC0 = 8'h10;
	localparam logic [7:0] REG_JOB_REC1 = 8'h14;
	localparam logic [7:0] REG_JOB_REC2 = 8'h18;
	localparam logic [7:0] REG_INFO = 8'h1C;
	localparam logic [7:0] REG_IRQ_STAT = 8'h20;
	localparam logic [7:0] REG_IRQ_CLR = 8'h24;
	localparam logic [7:0] REG_IRQ_EN = 8'h28;
	localparam int CMD_RX_BIT = 8;
	localparam int CMD_GATE_BIT = 9;
	localparam int CMD_LEN_LSB = 16;
	localparam int INFO_CFG_OK = 8;
	localparam int INFO_APF = 9;
	localparam int INFO_AUTO = 10;
	localparam int INFO_BUSY = 11;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR = 1;
	localparam int IRQ_PERR = 2;
	localparam int IRQ_APF = 3;
	localparam int IRQ_W = 4;

	function automatic logic job_valid(input logic [7:0] num);
		return (num >= JOB_FIRST) && (num <= JOB_LAST);
	endfunction

	function automatic logic [1:0] job_index(input logic [7:0] num);
		logic [7:0] d;
		d = num - JOB_FIRST;
		return d[1:0];
	endfunction
endpackage

// ==== hdl/job_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// job exchange between the controller and the module
interface job_link_if #(parameter int IMG_W = 16);
	logic start;
	logic [7:0] job_num;
	logic job_rx;
	logic gate;
	logic [7:0] len_words;
	logic [IMG_W-1:0] out_image;
	logic auto_en;
	logic busy;
	logic done;
	logic [7:0] done_num;
	logic [15:0] stat_word;
	logic [15:0] len_word;
	logic perr;
	logic [7:0] perr_byte;
	logic [IMG_W-1:0] in_image;
	logic cfg_ok;
	logic bus_power_fail_flag;
	logic auto_en_rb;

	modport dev (
		input start, job_num, job_rx, gate, len_words, out_image, auto_en,
		output busy, done, done_num, stat_word, len_word, perr, perr_byte,
		output in_image, cfg_ok, bus_power_fail_flag, auto_en_rb
	);
	modport host (
		output start, job_num, job_rx, gate, len_words, out_image, auto_en,
		input busy, done, done_num, stat_word, len_word, perr, perr_byte,
		input in_image, cfg_ok, bus_power_fail_flag, auto_en_rb
	);
endinterface
`default_nettype wire

// ==== hdl/tick_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
// one-cycle enable every DIV clocks
module tick_divider #(parameter int DIV = 4) (
	input wire logic pclk,
	input wire logic presetn,
	output logic tick
);
	logic [31:0] cnt_q;

	// free-running count, pulse on wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (cnt_q == 32'(DIV - 1)) begin
			cnt_q <= 32'h0000_0000;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h0000_0001;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== hdl/job_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
// controller end: APB registers, issues jobs, stores records
module job_controller
	import job_status_pkg::*;
#(
	parameter int IMG_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	job_link_if.host link
);
	logic [31:0] rec_q [3];
	logic busy_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_en_q;
	logic [IRQ_W-1:0] irq_ev;
	logic [IRQ_W-1:0] irq_clr;
	logic apf_q;
	logic wr_go;
	logic cmd_wr;
	logic local_err;

	assign wr_go = psel && penable && pready && pwrite;
	assign cmd_wr = wr_go && paddr == REG_CMD && !busy_q && !link.busy;
	assign local_err = cmd_wr && pwdata[CMD_GATE_BIT] && job_valid(pwdata[7:0]);
	assign irq_clr = (wr_go && paddr == REG_IRQ_CLR) ? pwdata[IRQ_W-1:0] : '0;

	// setup cycle prepares the answer; access ends one edge later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			unique case (paddr)
				REG_CMD, REG_IRQ_CLR: prdata <= 32'h0000_0000;
				REG_CTRL: prdata <= {31'h0000_0000, link.auto_en};
				REG_OUT_IMG: prdata <= 32'(link.out_image);
				REG_IN_IMG: prdata <= 32'(link.in_image); // RULE_12
				REG_JOB_REC0: prdata <= rec_q[0]; // RULE_02
				REG_JOB_REC1: prdata <= rec_q[1];
				REG_JOB_REC2: prdata <= rec_q[2];
				REG_INFO: prdata <= {20'h0_0000, busy_q, link.auto_en_rb, link.bus_power_fail_flag,
					link.cfg_ok, link.perr_byte}; // RULE_10 RULE_15
				REG_IRQ_STAT: prdata <= 32'(irq_stat_q);
				REG_IRQ_EN: prdata <= 32'(irq_en_q);
				default: pslverr <= 1'b1;
			endcase
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// software settings and the job command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link.start <= 1'b0;
			link.job_num <= 8'h00;
			link.job_rx <= 1'b0;
			link.gate <= 1'b0;
			link.len_words <= 8'h00;
			link.out_image <= '0;
			link.auto_en <= 1'b0;
			irq_en_q <= '0;
		end else begin
			link.start <= 1'b0;
			if (wr_go && paddr == REG_CTRL) begin
				link.auto_en <= pwdata[0]; // RULE_16
			end
			if (wr_go && paddr == REG_OUT_IMG) begin
				link.out_image <= pwdata[IMG_W-1:0]; // RULE_12
			end
			if (wr_go && paddr == REG_IRQ_EN) begin
				irq_en_q <= pwdata[IRQ_W-1:0];
			end
			// a gated job never reaches the module
			if (cmd_wr && !pwdata[CMD_GATE_BIT]) begin
				link.start <= 1'b1;
				link.job_num <= pwdata[7:0];
				link.job_rx <= pwdata[CMD_RX_BIT];
				link.gate <= 1'b0; // RULE_06
				link.len_words <= pwdata[CMD_LEN_LSB +: 8];
			end
		end
	end

	// one job at a time; records kept per job number
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			for (int i = 0; i < 3; i++) begin
				rec_q[i] <= 32'h0000_0000;
			end
		end else begin
			if (cmd_wr && !pwdata[CMD_GATE_BIT]) begin
				busy_q <= 1'b1;
			end
			if (local_err) begin
				rec_q[job_index(pwdata[7:0])] <= {16'h0000,
					4'h0, ERR_GATED, 8'h08}; // RULE_06 RULE_18
			end
			// captured in the very cycle the module finishes
			if (link.done) begin
				busy_q <= 1'b0;
				rec_q[job_index(link.done_num)] <= {link.len_word, link.stat_word}; // RULE_01 RULE_09
			end
			if (link.perr) begin
				busy_q <= 1'b0;
			end
		end
	end

	// sticky events; a new event beats a same-cycle clear
	always_comb begin
		irq_ev = '0;
		irq_ev[IRQ_DONE] = link.done && link.stat_word[ST_OK];
		irq_ev[IRQ_ERR] = (link.done && link.stat_word[ST_ERR]) || local_err; // RULE_07
		irq_ev[IRQ_PERR] = link.perr;
		irq_ev[IRQ_APF] = link.bus_power_fail_flag && !apf_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= '0;
			apf_q <= 1'b0;
			irq <= 1'b0;
		end else begin
			apf_q <= link.bus_power_fail_flag;
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
			irq <= |(((irq_stat_q & ~irq_clr) | irq_ev) & irq_en_q);
		end
	end
endmodule
`default_nettype wire

// ==== test/job_status_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// watches the job link between controller and module
module job_status_monitor
	import job_status_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [7:0] job_num,
	input wire logic job_rx,
	input wire logic gate,
	input wire logic [7:0] len_words,
	input wire logic busy,
	input wire logic done,
	input wire logic [7:0] done_num,
	input wire logic [15:0] stat_word,
	input wire logic [15:0] len_word,
	input wire logic perr,
	input wire logic [7:0] perr_byte
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// a start taken while idle, split by job number range
	logic take_ok, take_bad;
	assign take_ok = start && !busy && job_num >= JOB_FIRST && job_num <= JOB_LAST;
	assign take_bad = start && !busy && !(job_num >= JOB_FIRST && job_num <= JOB_LAST);

	chk_done_num: assert property (done |-> done_num >= JOB_FIRST && done_num <= JOB_LAST)
		else $error("done for a job number outside the range");
	chk_done_window: assert property (take_ok |-> ##[2:260] done)
		else $error("job did not finish in time");
	chk_bad_job: assert property (take_bad |=> perr && !done && perr_byte == PERR_BAD_JOB)
		else $error("bad job number not reported in error byte");
	chk_busy_active: assert property (take_ok |=> busy && stat_word[ST_ACTIVE])
		else $error("active bit missing after start");
	chk_one_result: assert property (done |-> (stat_word[ST_OK] ^ stat_word[ST_ERR]) && !stat_word[ST_ACTIVE])
		else $error("finished job must be ok or error, not active");
	chk_dir_bits: assert property (done && stat_word[ST_OK] |-> stat_word[DM_SEND_OK] == !job_rx && stat_word[DM_ACCEPT_OK] == job_rx && stat_word[ST_RX_AVAIL] == job_rx)
		else $error("data management bits wrong for direction");
	chk_ok_length: assert property (done && stat_word[ST_OK] |-> len_word == {8'h00, len_words})
		else $error("length word differs from words moved");
	chk_err_code: assert property (done && stat_word[ST_ERR] |-> len_word == 16'h0000 && stat_word[11:8] >= 4'h6)
		else $error("module error code or length wrong");
	chk_spare_zero: assert property (done |-> stat_word[15:12] == 4'h0 && !stat_word[DM_XFER_ACT] && !stat_word[DM_GATE])
		else $error("reserved, transfer or gate bit not zero");
	chk_gate_low: assert property (!gate)
		else $error("gate bit raised on the link");
endmodule
`default_nettype wire

// ==== test/job_status_word_reporting_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module job_status_word_reporting_bench
	import job_status_pkg::*;
();
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, irq, bus_power_ok = 1, sw_store_cfg = 0, sw_mode = 0;
	logic [15:0] slave_in_image = 16'h3C5A, slave_out_image;
	logic [30:0] slave_present = 31'h0000_00F0;
	logic led_cfg_ok, led_power_fail, auto_addr_en;
	logic [31:0] rd;
	logic er;
	int n_errors = 0, checks_done = 0;
	typedef struct {logic [31:0] cmd; logic mode; logic [7:0] rec; logic [31:0] exp_rec; logic [3:0] exp_irq;} row_t;
	row_t rows[8] = '{
		'{32'h0008_00C8, 0, 8'h10, 32'h0008_0024, 4'h1},
		'{32'h0004_01C9, 0, 8'h14, 32'h0004_0045, 4'h1},
		'{32'h0002_00CA, 0, 8'h18, 32'h0002_0024, 4'h1},
		'{32'h0002_00CA, 1, 8'h18, 32'h0000_0808, 4'h2},
		'{32'h0005_00C8, 0, 8'h10, 32'h0000_0608, 4'h2},
		'{32'h0008_02C8, 0, 8'h10, 32'h0000_0108, 4'h2},
		'{32'h0008_00C7, 0, 8'h10, 32'h0000_0108, 4'h4},
		'{32'h0008_00CB, 0, 8'h18, 32'h0000_0808, 4'h4}};

	always #2.5 pclk = ~pclk;

	job_link_if #(.IMG_W(16)) job_link_if_inst();
	job_controller #(.IMG_W(16)) job_controller_inst(.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .link(job_link_if_inst));
	// short polling period keeps the run brief
	job_module #(.IMG_W(16), .SLAVES(31), .POLL_CLKS(8)) job_module_inst(.pclk(pclk),
		.presetn(presetn), .link(job_link_if_inst), .slave_in_image(slave_in_image),
		.slave_present(slave_present), .bus_power_ok(bus_power_ok), .sw_store_cfg(sw_store_cfg),
		.sw_mode(sw_mode), .slave_out_image(slave_out_image), .led_cfg_ok(led_cfg_ok),
		.led_power_fail(led_power_fail), .auto_addr_en(auto_addr_en));
	job_status_monitor job_status_monitor_inst(.pclk(pclk), .presetn(presetn),
		.start(job_link_if_inst.start), .job_num(job_link_if_inst.job_num),
		.job_rx(job_link_if_inst.job_rx), .gate(job_link_if_inst.gate),
		.len_words(job_link_if_inst.len_words), .busy(job_link_if_inst.busy),
		.done(job_link_if_inst.done), .done_num(job_link_if_inst.done_num),
		.stat_word(job_link_if_inst.stat_word), .len_word(job_link_if_inst.len_word),
		.perr(job_link_if_inst.perr), .perr_byte(job_link_if_inst.perr_byte));

	task close_out();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one apb transfer; request held until pready is sampled high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (n = 0; n < 16; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (n == 16) begin
			n_errors++;
			close_out();
		end
	endtask

	task rd_chk(input string what, input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		apb(0, a, 32'h0);
		check(what, rd & mask, exp);
	endtask

	task wait_cycles(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// polls the sticky status until any event shows
	task wait_irq();
		int n;
		for (n = 0; n < 64; n++) begin
			apb(0, REG_IRQ_STAT, 32'h0);
			if (rd[3:0] !== 4'h0) break;
		end
		if (n == 64) begin
			n_errors++;
			close_out();
		end
	endtask

	initial begin
		wait_cycles(20);
		presetn <= 1;
		apb(1, REG_IRQ_EN, 32'h0000_000F);
		foreach (rows[i]) begin
			sw_mode <= rows[i].mode;
			apb(1, REG_CMD, rows[i].cmd);
			wait_irq();
			check("irq status", {28'h0, rd[3:0]}, {28'h0, rows[i].exp_irq});
			check("irq line", {31'h0, irq}, 32'h1);
			rd_chk("record", rows[i].rec, 32'hFFFF_FFFF, rows[i].exp_rec);
			if (rows[i].exp_irq == 4'h4) rd_chk("param byte", REG_INFO, 32'hFF, 32'h01);
			apb(1, REG_IRQ_CLR, 32'h0000_000F);
			wait_cycles(2);
			check("irq cleared", {31'h0, irq}, 32'h0);
			$display("row %0d done", i);
		end
		// command while busy is dropped: only one job runs
		sw_mode <= 0;
		apb(1, REG_CMD, 32'h0008_00C8);
		apb(1, REG_CMD, 32'h0004_01C9);
		wait_irq();
		apb(1, REG_IRQ_CLR, 32'h0000_000F);
		wait_cycles(30);
		rd_chk("no second job", REG_IRQ_STAT, 32'hF, 32'h0);
		rd_chk("job 200 again", REG_JOB_REC0, 32'hFFFF_FFFF, 32'h0008_0024);
		$display("busy refusal done");
		rd_chk("unmapped", 8'h30, 32'hFFFF_FFFF, 32'h0);
		check("unmapped error", {31'h0, er}, 32'h1);
		// auto address enable is the one setting kept
		apb(1, REG_CTRL, 32'h0000_0001);
		wait_cycles(3);
		check("auto pin", {31'h0, auto_addr_en}, 32'h1);
		rd_chk("auto readback", REG_INFO, 32'h400, 32'h400);
		// images swap on the polling tick
		apb(1, REG_OUT_IMG, 32'h0000_A5C3);
		// one polling period of 8 plus the output register, with one spare
		wait_cycles(10);
		check("out image", {16'h0, slave_out_image}, 32'h0000_A5C3);
		rd_chk("in image", REG_IN_IMG, 32'hFFFF, 32'h3C5A);
		$display("image test done");
		// a slave goes missing; job 202 already stored the full set
		slave_present <= 31'h0000_0070;
		wait_cycles(20);
		check("cfg led off", {31'h0, led_cfg_ok}, 32'h0);
		rd_chk("cfg flag off", REG_INFO, 32'h100, 32'h0);
		// switch ignored in protected mode
		sw_mode <= 1;
		sw_store_cfg <= 1;
		wait_cycles(4);
		sw_store_cfg <= 0;
		wait_cycles(4);
		check("cfg kept in protected", {31'h0, led_cfg_ok}, 32'h0);
		// config mode: switch stores what is there now
		sw_mode <= 0;
		sw_store_cfg <= 1;
		wait_cycles(4);
		sw_store_cfg <= 0;
		wait_cycles(20);
		check("cfg led", {31'h0, led_cfg_ok}, 32'h1);
		rd_chk("cfg flag", REG_INFO, 32'h100, 32'h100);
		// power fail with interrupt masked, then unmasked
		apb(1, REG_IRQ_EN, 32'h0);
		bus_power_ok <= 0;
		wait_cycles(20);
		check("power led", {31'h0, led_power_fail}, 32'h1);
		rd_chk("power flag", REG_INFO, 32'h200, 32'h200);
		rd_chk("power event", REG_IRQ_STAT, 32'hF, 32'h8);
		check("masked irq", {31'h0, irq}, 32'h0);
		apb(1, REG_IRQ_EN, 32'h0000_0008);
		wait_cycles(3);
		check("unmasked irq", {31'h0, irq}, 32'h1);
		apb(1, REG_IRQ_CLR, 32'h0000_0008);
		wait_cycles(2);
		check("irq after clear", {31'h0, irq}, 32'h0);
		$display("flag test done");
		// reset in mid run clears the records
		// power back first, else its rise after reset is a genuine new event
		bus_power_ok <= 1;
		presetn <= 0;
		wait_cycles(3);
		presetn <= 1;
		rd_chk("record reset", REG_JOB_REC0, 32'hFFFF_FFFF, 32'h0);
		rd_chk("status reset", REG_IRQ_STAT, 32'hF, 32'h0);
		$display("reset test done");
		close_out();
	end
endmodule
`default_nettype wire
